// File: rtl/trc_pkg.sv
// package for the timer repeat, clock select and capture block
`default_nettype none
package trc_pkg;
  // register byte offsets
  localparam logic [7:0] TIMER_CONTROL_OFS   = 8'h00;
  localparam logic [7:0] SLAVE_MODE_OFS      = 8'h08;
  localparam logic [7:0] INT_ENABLE_OFS      = 8'h0C;
  localparam logic [7:0] FLAG_OFS            = 8'h10;
  localparam logic [7:0] EVENT_GEN_OFS       = 8'h14;
  localparam logic [7:0] CHANNEL_MODE_OFS    = 8'h18;
  localparam logic [7:0] CHANNEL_ENABLE_OFS  = 8'h20;
  localparam logic [7:0] COUNT_OFS           = 8'h24;
  localparam logic [7:0] PRESCALER_OFS       = 8'h28;
  localparam logic [7:0] AUTO_RELOAD_OFS     = 8'h2C;
  localparam logic [7:0] REPEAT_COUNT_OFS    = 8'h30;
  localparam logic [7:0] CHAN1_VALUE_OFS     = 8'h34;
  localparam logic [7:0] CHAN2_VALUE_OFS     = 8'h38;
  // timer control fields
  localparam int CTL_RUN_BIT = 0;
  localparam int CTL_URS_BIT = 2;
  localparam int CTL_DIR_BIT = 4;
  localparam int CTL_CMS_LSB = 5;
  // slave mode fields
  localparam int SMC_SMS_LSB = 0;
  localparam int SMC_TS_LSB  = 4;
  localparam int SMC_ETF_LSB = 8;
  localparam int SMC_EXTERNAL_TRIGGER_DIVIDER_LSB = 12;
  localparam int SMC_ECE_BIT = 14;
  localparam int SMC_ETP_BIT = 15;
  // flag register fields
  localparam int FLG_UIF_BIT = 0;
  localparam int FLG_CC1_BIT = 1;
  localparam int FLG_TIF_BIT = 6;
  localparam int FLG_OF1_BIT = 9;
  // channel mode fields, one byte per channel
  localparam int CHM_SEL_LSB = 0;
  localparam int CHM_PSC_LSB = 2;
  localparam int CHM_FLT_LSB = 4;
  localparam int CHM_STRIDE  = 8;
  // channel enable fields, four bits per channel
  localparam int CHE_EN_BIT  = 0;
  localparam int CHE_POL_BIT = 1;
  localparam int CHE_STRIDE  = 4;
  // event generation bits
  localparam int EGR_UG_BIT  = 0;
  localparam int EGR_CC1_BIT = 1;
  // codes
  localparam logic [2:0] SMS_OFF    = 3'h0;
  localparam logic [2:0] SMS_EXTCK1 = 3'h7;
  localparam logic [2:0] TS_TI1FP1  = 3'h5;
  localparam logic [2:0] TS_TI2FP2  = 3'h6;
  localparam logic [2:0] TS_ITR_MAX = 3'h3;
  localparam logic [15:0] ARR_RESET = 16'hFFFF;
  // one-cycle event bundle passed around the counter
  typedef struct packed {
    logic tick;   // counter advance enable
    logic trig;   // trigger edge seen
    logic upd;    // forced update
  } trc_evt_t;
endpackage
`default_nettype wire

// File: rtl/trc_timer.sv
// repetition counter, counter clock selection and input capture channels
`default_nettype none
module trc_timer
#(
  parameter int NCH = 2
) (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [NCH-1:0] CH_IN,
  input  wire logic        EXT_TRIG_IN,
  input  wire logic [3:0]  INT_TRIG_IN,
  output logic             TIMER_IRQ,
  output logic             UPDATE_EVENT
);
  import trc_pkg::*;
  if (NCH != 2) $error("trc_timer serves exactly two channels");
  logic [31:0] ctl_r, smc_r, ier_r, chm_r, che_r;
  logic [15:0] cnt_r, psc_pre_r, psc_sh_r, psc_cnt_r, arr_pre_r, arr_sh_r;
  logic [7:0]  rcr_pre_r, rep_r;
  logic [15:0] ccr_r [NCH];
  logic [NCH-1:0] ccf_r, ocf_r;
  logic        uif_r, tif_r;
  logic        wr_pend_r, rd_pend_r;
  logic [7:0]  wr_addr_r;
  logic [NCH-1:0] rd_clear;
  // bus address phase capture
  logic        acc;
  assign acc = HSEL && HREADY && HTRANS[1];
  // channel input chain: filter, edge select, capture divider
  logic [NCH-1:0] flt_r, flt_q_r, edge_act;
  logic [NCH-1:0] cap_evt;
  logic [7:0]  flt_cnt_r [NCH];

  // filter code to sample run length
  function automatic logic [7:0] flt_len(input logic [3:0] code);
    unique case (code)
      4'h0: flt_len = 8'h01;
      4'h1: flt_len = 8'h02;
      4'h2: flt_len = 8'h04;
      4'h3: flt_len = 8'h08;
      default: flt_len = {code, 4'h0};
    endcase
  endfunction
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : ch
      logic [3:0] fcode;
      logic [1:0] pcode;
      logic       pol, en, inmode;
      assign fcode  = chm_r[g*CHM_STRIDE+CHM_FLT_LSB +: 4];
      assign pcode  = chm_r[g*CHM_STRIDE+CHM_PSC_LSB +: 2];
      assign inmode = chm_r[g*CHM_STRIDE+CHM_SEL_LSB +: 2] != 2'h0;
      assign pol    = che_r[g*CHE_STRIDE+CHE_POL_BIT];
      assign en     = che_r[g*CHE_STRIDE+CHE_EN_BIT];
      // run-length filter: input taken as synchronous, so no extra stages
      always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
          flt_r[g]     <= 1'b0;
          flt_cnt_r[g] <= 8'h00;
        end else if (CH_IN[g] == flt_r[g]) begin
          flt_cnt_r[g] <= 8'h00;
        end else if (flt_cnt_r[g] + 8'h01 >= flt_len(fcode)) begin
          flt_r[g]     <= CH_IN[g];
          flt_cnt_r[g] <= 8'h00;
        end else begin
          flt_cnt_r[g] <= flt_cnt_r[g] + 8'h01;
        end
      end
      always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) flt_q_r[g] <= 1'b0;
        else flt_q_r[g] <= flt_r[g];
      end
      // polarity-selected edge of the filtered input
      assign edge_act[g] = pol ? (flt_q_r[g] & ~flt_r[g]) : (~flt_q_r[g] & flt_r[g]);
      // input prescaler: 00 every edge, else every 2, 4, 8
      logic [2:0] div_cnt_r;
      logic [2:0] div_max;
      assign div_max = (3'h1 << pcode) - 3'h1;
      always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) div_cnt_r <= 3'h0;
        else if (!en || !inmode) div_cnt_r <= 3'h0;
        else if (edge_act[g]) div_cnt_r <= (div_cnt_r >= div_max) ? 3'h0 : div_cnt_r + 3'h1;
      end
      assign cap_evt[g] = inmode && en && edge_act[g] && (div_cnt_r >= div_max);
    end
  endgenerate
  // external trigger path: polarity, run-length filter, edge divider
  logic       etr_pol, etr_f_r, etr_q_r, etr_edge;
  logic [7:0] etr_cnt_r;
  logic [2:0] etr_div_r;
  logic       prescaled_external_trigger;
  assign etr_pol = EXT_TRIG_IN ^ smc_r[SMC_ETP_BIT];
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      etr_f_r   <= 1'b0;
      etr_cnt_r <= 8'h00;
    end else if (etr_pol == etr_f_r) begin
      etr_cnt_r <= 8'h00;
    end else if (etr_cnt_r + 8'h01 >= flt_len(smc_r[SMC_ETF_LSB +: 4])) begin
      etr_f_r   <= etr_pol;
      etr_cnt_r <= 8'h00;
    end else begin
      etr_cnt_r <= etr_cnt_r + 8'h01;
    end
  end
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) etr_q_r <= 1'b0;
    else etr_q_r <= etr_f_r;
  end
  assign etr_edge = etr_f_r & ~etr_q_r;
  // edge divider 1, 2, 4, 8; three bits so the slowest setting spans eight edges
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) etr_div_r <= 3'h0;
    else if (etr_edge) etr_div_r <= etr_div_r + 3'h1;
  end
  always_comb begin
    unique case (smc_r[SMC_EXTERNAL_TRIGGER_DIVIDER_LSB +: 2])
      2'h0: prescaled_external_trigger = etr_edge;
      2'h1: prescaled_external_trigger = etr_edge & etr_div_r[0];
      2'h2: prescaled_external_trigger = etr_edge & (etr_div_r[1:0] == 2'h3);
      default: prescaled_external_trigger = etr_edge & (etr_div_r == 3'h7);
    endcase
  end
  // trigger selection and clock source
  logic [2:0] slave_mode_select, ts;
  logic       trg, int_tick;
  logic [3:0] itr_q_r;
  assign slave_mode_select = smc_r[SMC_SMS_LSB +: 3];
  assign ts  = smc_r[SMC_TS_LSB +: 3];
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) itr_q_r <= 4'h0;
    else itr_q_r <= INT_TRIG_IN;
  end
  // trigger mux: internal triggers, channel one or two edges
  always_comb begin
    if (ts <= TS_ITR_MAX) trg = INT_TRIG_IN[ts[1:0]] & ~itr_q_r[ts[1:0]];
    else if (ts == TS_TI1FP1) trg = edge_act[0];
    else if (ts == TS_TI2FP2) trg = edge_act[1];
    else trg = 1'b0;
  end
  trc_evt_t ev;
  // prescaler input: trigger edges in mode one, pin edges in mode two, else clock
  always_comb begin
    ev.trig = trg && (slave_mode_select != SMS_OFF);
    ev.upd  = 1'b0;
    if (slave_mode_select == SMS_EXTCK1) ev.tick = trg;
    else if (smc_r[SMC_ECE_BIT]) ev.tick = prescaled_external_trigger;
    else ev.tick = 1'b1;
  end
  // counter and repetition
  logic run, psc_tick, ovf, udf, wrap, sw_ug, upd, dir_dn;
  logic [1:0] cms;
  logic [NCH-1:0] sw_cc;
  logic ctl_wr;
  assign run    = ctl_r[CTL_RUN_BIT];
  assign cms    = ctl_r[CTL_CMS_LSB +: 2];
  assign dir_dn = ctl_r[CTL_DIR_BIT];
  assign psc_tick = run && ev.tick && (psc_cnt_r == psc_sh_r);
  always_comb begin
    ovf = 1'b0;
    udf = 1'b0;
    if (psc_tick) begin
      if (cms != 2'h0) begin
        ovf = !dir_dn && (cnt_r + 16'h0001 >= arr_sh_r);
        udf = dir_dn && (cnt_r <= 16'h0001);
      end else begin
        ovf = !dir_dn && (cnt_r >= arr_sh_r);
        udf = dir_dn && (cnt_r == 16'h0000);
      end
    end
  end
  assign wrap = ovf | udf;
  // ug is self clearing: it exists only in the write cycle
  assign sw_ug  = wr_pend_r && wr_addr_r == EVENT_GEN_OFS && HWDATA[EGR_UG_BIT];
  assign sw_cc  = (wr_pend_r && wr_addr_r == EVENT_GEN_OFS) ? HWDATA[EGR_CC1_BIT +: NCH] : '0;
  assign upd    = sw_ug || (wrap && rep_r == 8'h00);
  assign ctl_wr = wr_pend_r && wr_addr_r == TIMER_CONTROL_OFS;
  // prescaler counter, cleared by update
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) psc_cnt_r <= 16'h0000;
    else if (sw_ug || psc_tick) psc_cnt_r <= 16'h0000;
    else if (run && ev.tick) psc_cnt_r <= psc_cnt_r + 16'h0001;
  end
  // main counter; center mode turns direction at the ends
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) cnt_r <= 16'h0000;
    else if (sw_ug) cnt_r <= dir_dn && cms == 2'h0 ? arr_sh_r : 16'h0000;
    else if (wr_pend_r && wr_addr_r == COUNT_OFS) cnt_r <= HWDATA[15:0];
    else if (psc_tick) begin
      if (ovf) cnt_r <= (cms != 2'h0) ? arr_sh_r : 16'h0000;
      else if (udf) cnt_r <= (cms != 2'h0) ? 16'h0000 : (upd ? arr_pre_r : arr_sh_r);
      else cnt_r <= dir_dn ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
    end
  end
  // repetition counter
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) rep_r <= 8'h00;
    else if (upd) rep_r <= rcr_pre_r;
    else if (wrap) rep_r <= rep_r - 8'h01;
  end
  // shadow transfer on every qualified update
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      arr_sh_r <= ARR_RESET;
      psc_sh_r <= 16'h0000;
    end else if (upd) begin
      arr_sh_r <= arr_pre_r;
      psc_sh_r <= psc_pre_r;
    end
  end
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) UPDATE_EVENT <= 1'b0;
    else UPDATE_EVENT <= upd;
  end
  // bus slave: write strobe and word address held for the data phase
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= acc && HWRITE;
      wr_addr_r <= {HADDR[7:2], 2'b00};
    end
  end
  // software-owned registers; center mode direction is also set by hardware at the ends, a control write wins
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctl_r <= 32'h0; smc_r <= 32'h0; ier_r <= 32'h0; chm_r <= 32'h0; che_r <= 32'h0;
      psc_pre_r <= 16'h0; arr_pre_r <= ARR_RESET; rcr_pre_r <= 8'h0;
    end else begin
      if (ctl_wr) ctl_r <= HWDATA;
      else if (cms != 2'h0 && (ovf || udf)) ctl_r[CTL_DIR_BIT] <= ovf;
      if (wr_pend_r && wr_addr_r == SLAVE_MODE_OFS) smc_r <= HWDATA;
      if (wr_pend_r && wr_addr_r == INT_ENABLE_OFS) ier_r <= HWDATA;
      if (wr_pend_r && wr_addr_r == CHANNEL_MODE_OFS) chm_r <= HWDATA;
      if (wr_pend_r && wr_addr_r == CHANNEL_ENABLE_OFS) che_r <= HWDATA;
      if (wr_pend_r && wr_addr_r == PRESCALER_OFS) psc_pre_r <= HWDATA[15:0];
      if (wr_pend_r && wr_addr_r == AUTO_RELOAD_OFS) arr_pre_r <= HWDATA[15:0];
      if (wr_pend_r && wr_addr_r == REPEAT_COUNT_OFS) rcr_pre_r <= HWDATA[7:0];
    end
  end
  // capture registers and flags
  logic flag_wr;
  assign flag_wr = wr_pend_r && wr_addr_r == FLAG_OFS;
  generate
    for (g = 0; g < NCH; g++) begin : cap
      logic take, inmode;
      logic [7:0] ofs;
      assign ofs    = CHAN1_VALUE_OFS + 8'(4 * g);
      assign inmode = chm_r[g*CHM_STRIDE+CHM_SEL_LSB +: 2] != 2'h0;
      assign take   = cap_evt[g] || (sw_cc[g] && inmode);
      // capture loads ccr_r directly; bus writes reach it only when the channel is not an input
      always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) ccr_r[g] <= 16'h0000;
        else if (take) ccr_r[g] <= cnt_r;
        else if (!inmode && wr_pend_r && wr_addr_r == ofs) ccr_r[g] <= HWDATA[15:0];
      end
      // set wins over every clear
      always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
          ccf_r[g] <= 1'b0;
          ocf_r[g] <= 1'b0;
        end else begin
          if (take || sw_cc[g]) ccf_r[g] <= 1'b1;
          else if ((flag_wr && !HWDATA[FLG_CC1_BIT+g]) || rd_clear[g]) ccf_r[g] <= 1'b0;
          if (take && ccf_r[g]) ocf_r[g] <= 1'b1;
          else if (flag_wr && !HWDATA[FLG_OF1_BIT+g]) ocf_r[g] <= 1'b0;
        end
      end
      assign rd_clear[g] = rd_pend_r && wr_addr_r == ofs && inmode;
    end
  endgenerate

  // update and trigger flags
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      uif_r <= 1'b0;
      tif_r <= 1'b0;
    end else begin
      if (upd && !(sw_ug && ctl_r[CTL_URS_BIT])) uif_r <= 1'b1;
      else if (flag_wr && !HWDATA[FLG_UIF_BIT]) uif_r <= 1'b0;
      if (ev.trig) tif_r <= 1'b1;
      else if (flag_wr && !HWDATA[FLG_TIF_BIT]) tif_r <= 1'b0;
    end
  end
  // read data registered in the address phase: answer has zero wait states
  logic [31:0] rd_nxt;
  logic [31:0] flags;
  assign flags = 32'(ocf_r) << FLG_OF1_BIT | 32'(tif_r) << FLG_TIF_BIT
               | 32'(ccf_r) << FLG_CC1_BIT | 32'(uif_r);
  always_comb begin
    unique case ({HADDR[7:2], 2'b00})
      TIMER_CONTROL_OFS:  rd_nxt = ctl_r;
      SLAVE_MODE_OFS:     rd_nxt = smc_r;
      INT_ENABLE_OFS:     rd_nxt = ier_r;
      FLAG_OFS:           rd_nxt = flags;
      CHANNEL_MODE_OFS:   rd_nxt = chm_r;
      CHANNEL_ENABLE_OFS: rd_nxt = che_r;
      COUNT_OFS:          rd_nxt = {16'h0, cnt_r};
      PRESCALER_OFS:      rd_nxt = {16'h0, psc_pre_r};
      AUTO_RELOAD_OFS:    rd_nxt = {16'h0, arr_pre_r};
      REPEAT_COUNT_OFS:   rd_nxt = {24'h0, rcr_pre_r};
      CHAN1_VALUE_OFS:    rd_nxt = {16'h0, ccr_r[0]};
      CHAN2_VALUE_OFS:    rd_nxt = {16'h0, ccr_r[1]};
      default:            rd_nxt = 32'h0;
    endcase
  end
  // read data and the pending-read strobe that clears a capture flag
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HRDATA    <= 32'h0;
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= acc && !HWRITE;
      if (acc && !HWRITE) HRDATA <= rd_nxt;
    end
  end
  // address of the pending read shares wr_addr_r, loaded every cycle
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      TIMER_IRQ <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      TIMER_IRQ <= |(ccf_r & ier_r[FLG_CC1_BIT +: NCH]) | (uif_r & ier_r[FLG_UIF_BIT])
                 | (tif_r & ier_r[FLG_TIF_BIT]);
    end
  end
endmodule
`default_nettype wire

// File: test/trc_timer_properties.sv
// concurrent checks on the timer block ports
`default_nettype none
module trc_timer_properties
  import trc_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic           CLOCK,
  input wire logic           SYS_RST,
  input wire logic           HSEL,
  input wire logic [7:0]     HADDR,
  input wire logic [1:0]     HTRANS,
  input wire logic           HWRITE,
  input wire logic [2:0]     HSIZE,
  input wire logic [31:0]    HWDATA,
  input wire logic           HREADY,
  input wire logic [31:0]    HRDATA,
  input wire logic           HREADYOUT,
  input wire logic           HRESP,
  input wire logic [NCH-1:0] CH_IN,
  input wire logic           EXT_TRIG_IN,
  input wire logic [3:0]     INT_TRIG_IN,
  input wire logic           TIMER_IRQ,
  input wire logic           UPDATE_EVENT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        aph, ug, clr, wq_r, rq_r;
  logic [5:0]  aq_r;
  logic [31:0] m_r [16];
  logic [3:0]  quiet_r, clr_r;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // zero wait states, so the data phase is always the cycle after the address phase
  assign aph = HSEL && HREADY && HTRANS[1];
  assign ug  = wq_r && aq_r == 6'h05 && HWDATA[EGR_UG_BIT];
  assign clr = (wq_r && (aq_r == 6'h03 || aq_r == 6'h04)) || (rq_r && (aq_r == 6'h0D || aq_r == 6'h0E));
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wq_r <= 1'b0;
      rq_r <= 1'b0;
      aq_r <= 6'h00;
    end else begin
      wq_r <= aph && HWRITE;
      rq_r <= aph && !HWRITE;
      aq_r <= HADDR[7:2];
    end
  end
  // copy of written words; only control, slave mode and enables are looked at
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < 16; i++) begin
        m_r[i] <= 32'h0;
      end
    end else if (wq_r && aq_r[5:4] == 2'h0) begin
      m_r[aq_r[3:0]] <= HWDATA;
    end
  end
  // cycles since anything that may legally cause an update
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      quiet_r <= 4'hF;
    end else if (ug || m_r[0][CTL_RUN_BIT] || m_r[2][2:0] != 3'h0 || m_r[2][SMC_ECE_BIT]) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  // cycles since a flag clear or enable change, the only ways the request drops
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      clr_r <= 4'hF;
    end else if (clr) begin
      clr_r <= 4'h0;
    end else if (clr_r != 4'hF) begin
      clr_r <= clr_r + 4'h1;
    end
  end
  property p_ug;
    ug |-> ##[1:3] UPDATE_EVENT;
  endproperty
  a_ug: assert property (p_ug) else $error("software update gave no pulse");
  property p_ccg;
    wq_r && aq_r == 6'h05 && HWDATA[EGR_CC1_BIT] && m_r[3][FLG_CC1_BIT] && m_r[8][CHE_EN_BIT] |-> ##[1:4] TIMER_IRQ;
  endproperty
  a_ccg: assert property (p_ccg) else $error("generated capture raised no request");
  property p_irq_src;
    $rose(TIMER_IRQ) |-> m_r[3] != 32'h0 || $past(m_r[3]) != 32'h0;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("request with no enable");
  property p_irq_off;
    (m_r[3] == 32'h0) [*2] |-> !TIMER_IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while all enables off");
  property p_irq_fall;
    $fell(TIMER_IRQ) |-> clr_r < 4'h5;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped with no clear");
  property p_rdata;
    !(aph && !HWRITE) |=> $stable(HRDATA);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without a read");
  property p_okay;
    HREADYOUT && !HRESP;
  endproperty
  a_okay: assert property (p_okay) else $error("bus stalled or errored");
  property p_upd_src;
    UPDATE_EVENT |-> quiet_r < 4'h6;
  endproperty
  a_upd_src: assert property (p_upd_src) else $error("update while stopped");
  c_upd: cover property (UPDATE_EVENT && m_r[0][CTL_RUN_BIT]);
  c_irq: cover property ($rose(TIMER_IRQ));
  c_clr: cover property ($fell(TIMER_IRQ));
endmodule
bind trc_timer trc_timer_properties #(.NCH(NCH)) u_props (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CH_IN(CH_IN), .EXT_TRIG_IN(EXT_TRIG_IN),
  .INT_TRIG_IN(INT_TRIG_IN), .TIMER_IRQ(TIMER_IRQ), .UPDATE_EVENT(UPDATE_EVENT)
);
`default_nettype wire

// File: test/trc_pin_model.sv
// pin-side model of the channel, trigger pin and internal trigger lines
`default_nettype none
module trc_pin_model (
  input  wire logic clk,
  output logic [1:0] ch_in,
  output logic       ext_trig,
  output logic [3:0] int_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] pin_r = 7'h00;
  assign ch_in    = pin_r[1:0];
  assign ext_trig = pin_r[2];
  assign int_trig = pin_r[6:3];
  // called just after an edge; level then held n edges so the filters see it
  task automatic drive(input int sel, input logic v, input int n);
    pin_r[sel] <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: test/tb_timer_repeat_clock_capture.sv
// self-checking bench for the repeat, clock select and capture timer block
`default_nettype none
module tb_timer_repeat_clock_capture;
  timeunit 1ns;
  timeprecision 1ps;
  import trc_pkg::*;
  logic        clock, sys_rst, hsel, hwrite, hreadyout, hresp, ext_trig, irq, upd;
  logic [7:0]  haddr;
  logic [1:0]  htrans, ch_in;
  logic [31:0] hwdata, hrdata, junk;
  logic [3:0]  int_trig;
  int          errors, cmp_count, n;
  // modes: control word, prescaler, reload, repeat, expected update spacing
  int rc[4] = '{1, 17, 33, 1};
  int rp[4] = '{0, 0, 0, 1};
  int ra[4] = '{3, 3, 4, 3};
  int rr[4] = '{2, 2, 1, 0};
  int rx[4] = '{12, 12, 8, 8};
  // sources: slave mode word, channel mode, pin, edges given, expected count
  int sm[3] = '{32'h67, 32'h5000, 32'h7};
  int sc[3] = '{32'h100, 0, 0};
  int sp[3] = '{1, 2, 3};
  int se[3] = '{3, 4, 3};
  int sx[3] = '{3, 2, 3};
  trc_timer #(.NCH(2)) dut (
    .CLOCK(clock), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CH_IN(ch_in), .EXT_TRIG_IN(ext_trig),
    .INT_TRIG_IN(int_trig), .TIMER_IRQ(irq), .UPDATE_EVENT(upd)
  );
  trc_pin_model pins (.clk(clock), .ch_in(ch_in), .ext_trig(ext_trig), .int_trig(int_trig));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic hwait;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin
      errors++;
      stop_test;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hwait;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait;
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, junk);
  endtask
  // a few settling cycles first, since flags land a cycle or two after events
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] v;
    repeat (3) @(posedge clock);
    bus(1'b0, a, 32'h0, v);
    chk(nm, v & m, e);
  endtask
  task automatic wupd(output int k);
    for (k = 1; k < 200; k++) begin
      @(posedge clock);
      if (upd === 1'b1) break;
    end
    if (k == 200) begin
      errors++;
      stop_test;
    end
  endtask
  task automatic pulse(input int sel, input int hi, input int lo);
    pins.drive(sel, 1'b1, hi);
    pins.drive(sel, 1'b0, lo);
  endtask
  initial begin
    errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rdm(AUTO_RELOAD_OFS, 32'hFFFF, 32'hFFFF, "reload reset");
    rdm(8'h3C, 32'hFFFFFFFF, 32'h0, "unmapped");
    // update spacing for up, down, center and a slower prescaler
    for (int i = 0; i < 4; i++) begin
      wr(TIMER_CONTROL_OFS, 32'h0);
      wr(PRESCALER_OFS, 32'(rp[i]));
      wr(AUTO_RELOAD_OFS, 32'(ra[i]));
      wr(REPEAT_COUNT_OFS, 32'(rr[i]));
      wr(EVENT_GEN_OFS, 32'h1);
      wupd(n);
      wr(TIMER_CONTROL_OFS, 32'(rc[i]));
      repeat (3) wupd(n);
      chk("update spacing", 32'(n), 32'(rx[i]));
    end
    for (int i = 0; i < 2; i++) begin
      wr(FLAG_OFS, 32'h0);
      wr(TIMER_CONTROL_OFS, 32'(i) << CTL_URS_BIT);
      wr(EVENT_GEN_OFS, 32'h1);
      rdm(FLAG_OFS, 32'h1, 32'(1 - i), "update flag");
    end
    // captures with the counter held at known values
    wr(TIMER_CONTROL_OFS, 32'h0);
    wr(COUNT_OFS, 32'h55);
    wr(CHANNEL_MODE_OFS, 32'h1);
    wr(CHANNEL_ENABLE_OFS, 32'h1);
    wr(INT_ENABLE_OFS, 32'h2);
    wr(FLAG_OFS, 32'h0);
    pulse(0, 3, 6);
    rdm(FLAG_OFS, 32'h202, 32'h2, "capture flag");
    chk("irq", {31'h0, irq}, 32'h1);
    wr(CHAN1_VALUE_OFS, 32'h1234);
    wr(COUNT_OFS, 32'h66);
    pulse(0, 3, 6);
    rdm(FLAG_OFS, 32'h202, 32'h202, "overcapture");
    rdm(CHAN1_VALUE_OFS, 32'hFFFF, 32'h66, "captured value");
    rdm(FLAG_OFS, 32'h202, 32'h200, "flags after value read");
    wr(FLAG_OFS, 32'h0);
    rdm(FLAG_OFS, 32'h202, 32'h0, "flags after clear");
    wr(CHANNEL_MODE_OFS, 32'h31);
    pulse(0, 5, 12);
    rdm(FLAG_OFS, 32'h2, 32'h0, "short glitch");
    pulse(0, 14, 12);
    rdm(FLAG_OFS, 32'h2, 32'h2, "long level");
    wr(CHANNEL_MODE_OFS, 32'h1);
    wr(CHANNEL_ENABLE_OFS, 32'h3);
    wr(FLAG_OFS, 32'h0);
    pins.drive(0, 1'b1, 6);
    rdm(FLAG_OFS, 32'h2, 32'h0, "rising ignored");
    pins.drive(0, 1'b0, 6);
    rdm(FLAG_OFS, 32'h2, 32'h2, "falling taken");
    wr(CHANNEL_ENABLE_OFS, 32'h0);
    wr(FLAG_OFS, 32'h0);
    pulse(0, 3, 6);
    rdm(FLAG_OFS, 32'h2, 32'h0, "disabled channel");
    wr(CHANNEL_ENABLE_OFS, 32'h1);
    wr(EVENT_GEN_OFS, 32'h2);
    rdm(FLAG_OFS, 32'h2, 32'h2, "generated capture");
    chk("irq", {31'h0, irq}, 32'h1);
    wr(CHANNEL_MODE_OFS, 32'h0);
    wr(CHAN1_VALUE_OFS, 32'h4321);
    rdm(CHAN1_VALUE_OFS, 32'hFFFF, 32'h4321, "compare value");
    wr(INT_ENABLE_OFS, 32'h0);
    // counter clocked from channel two, trigger pin and internal trigger
    for (int j = 0; j < 3; j++) begin
      wr(TIMER_CONTROL_OFS, 32'h0);
      wr(SLAVE_MODE_OFS, 32'(sm[j]));
      wr(CHANNEL_MODE_OFS, 32'(sc[j]));
      wr(AUTO_RELOAD_OFS, 32'hFFFF);
      wr(PRESCALER_OFS, 32'h0);
      wr(EVENT_GEN_OFS, 32'h1);
      wr(COUNT_OFS, 32'h0);
      wr(FLAG_OFS, 32'h0);
      wr(TIMER_CONTROL_OFS, 32'h1);
      repeat (se[j]) pulse(sp[j], 2, 6);
      rdm(COUNT_OFS, 32'hFFFF, 32'(sx[j]), "edge count");
      if (j == 0) rdm(FLAG_OFS, 32'h40, 32'h40, "trigger flag");
    end
    stop_test;
  end
endmodule
`default_nettype wire
